// ==== irig_params.svh ====
// Purpose: named constants of the time-code time base
// Assumes: 50 MHz system clock
// Notes: times in their own unit, cycle counts derived where used
`ifndef IRIG_PARAMS_SVH
`define IRIG_PARAMS_SVH
`define CLK_MHZ 50
`define BASE_HZ 40000000
`define PPS_HIGH_MS 75
`define LOSS_MS 1500
`define US_PER_MS 1000
// symbol widths for the slow format, fast format is ten times shorter
`define W_MIN_US 1000
`define W_ZERO_US 3500
`define W_ONE_US 6500
`define W_MAX_US 9500
`define A_SCALE 10
`define MARK_PERIOD 7'd10
`define MARK_PHASE 7'd9
`define FRAME_LAST 7'd99
`define IDX_AFTER_REF 7'd1
`define DATA_LAST 41
`define P_SEC 1
`define P_MIN 10
`define P_HOUR 20
`define P_DAY 30
`define P_TENS 5
`define P_HUND 10
`define SEC_LAST 6'd59
`define MIN_LAST 6'd59
`define HOUR_LAST 5'd23
`define DAY_LAST 9'd366
`define DAY_FIRST 9'd1
`define NCO_INC_RST 32'hcccccccd
`define NCO_GAIN_SH 6
`define DIV_RST 22'h000014
`define DIV_MIN 32'h00000002
`define DIV_MAX 32'h001e8480
`define SYNC_HALF 22'h000002
`define REG_CTRL 5'h00
`define REG_DIV 5'h04
`define REG_STAT 5'h08
`define REG_TIME 5'h0c
`define REG_SEG 5'h10
`define REG_IST 5'h14
`define REG_IMASK 5'h18
`define CTRL_CODE_A 0
`define CTRL_AM 1
`define CTRL_ARM 2
`define CTRL_STOP 3
`define IRQ_SEC 0
`define IRQ_TIME 1
`define IRQ_LOSS 2
`define IRQ_RELOCK 3
`define IRQ_SEG 4
`define IRQ_START 5
`define IRQ_W 6
`endif

// ==== irig_pkg.sv ====
// Purpose: shared types of the time-code time base
// Assumes: nothing
// Notes: time of day is held in binary fields
`default_nettype none
package irig_pkg;
    typedef struct packed {
        logic [8:0] day;
        logic [4:0] hour;
        logic [5:0] min;
        logic [5:0] sec;
    } tod_t;
    typedef struct packed {
        logic code_a;
        logic am;
    } ctrl_t;
    typedef enum logic [2:0] {
        ST_UNLOCKED = 3'b001,
        ST_LOCKED = 3'b010,
        ST_HOLD = 3'b100
    } lock_state_t;
endpackage
`default_nettype wire

// ==== time_code_decoder.sv ====
// Purpose: pulse-width time-code decoder, second tick and time of day
// Assumes: code levels synchronous to clk_i
// Notes: tick comes one cycle after the on-time rising edge
`timescale 1ns/10ps
`default_nettype none
`include "irig_params.svh"
module time_code_decoder #(
    parameter int unsigned US_CYC = `CLK_MHZ
) (
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire irig_pkg::ctrl_t ctrl_i,
    input wire logic dc_level_i,
    input wire logic am_level_i,
    output logic tick_o,
    output logic frame_o,
    output irig_pkg::tod_t tod_o
);
    logic sig, sig_q, rise, fall, valid, mark, one, mpos;
    logic prev_mark_q, synced_q, err_q, armed_q, tick_q, frame_q;
    logic [31:0] width_q;
    logic [6:0] idx_q;
    logic [`DATA_LAST:0] data_q;

    function automatic logic [31:0] thr(input int unsigned us);
        thr = ctrl_i.code_a ? 32'(us * US_CYC / `A_SCALE) : 32'(us * US_CYC);
    endfunction

    function automatic logic [9:0] bcd(input logic [3:0] u, input logic [3:0] t,
                                       input logic [1:0] h);
        bcd = 10'(u) + 10'(t) * 10'd10 + 10'(h) * 10'd100;
    endfunction

    assign sig = ctrl_i.am ? am_level_i : dc_level_i;
    assign rise = sig & ~sig_q;
    assign fall = ~sig & sig_q;
    assign valid = (width_q >= thr(`W_MIN_US)) && (width_q < thr(`W_MAX_US));
    assign one = width_q >= thr(`W_ZERO_US);
    assign mark = width_q >= thr(`W_ONE_US);
    assign mpos = (idx_q % `MARK_PERIOD) == `MARK_PHASE;
    assign tick_o = tick_q;
    assign frame_o = frame_q;

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            sig_q <= 1'b0;
            width_q <= '0;
        end else begin
            sig_q <= sig;
            if (rise) begin
                width_q <= 32'h1;
            end else if (sig && width_q != '1) begin
                width_q <= width_q + 32'h1;
            end
        end
    end

    // symbol position, sync on two markers in a row
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            prev_mark_q <= 1'b0;
            synced_q <= 1'b0;
            err_q <= 1'b0;
            idx_q <= '0;
            data_q <= '0;
        end else if (fall) begin
            prev_mark_q <= valid & mark;
            if (!valid) begin
                synced_q <= 1'b0;
            end else if (mark && prev_mark_q) begin
                idx_q <= `IDX_AFTER_REF;
                synced_q <= 1'b1;
                err_q <= 1'b0;
            end else begin
                if (mark != mpos) begin
                    err_q <= 1'b1;
                end
                if (!mark && idx_q <= 7'(`DATA_LAST)) begin
                    data_q[idx_q[5:0]] <= one;
                end
                if (idx_q != `FRAME_LAST) begin
                    idx_q <= idx_q + 7'd1;
                end
            end
        end
    end

    // message ends before the next on-time edge
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            frame_q <= 1'b0;
            tod_o <= '0;
        end else begin
            frame_q <= fall && valid && mark && !prev_mark_q && synced_q && !err_q
                       && idx_q == `FRAME_LAST;
            if (fall && valid && mark && !prev_mark_q && synced_q && !err_q
                && idx_q == `FRAME_LAST) begin
                tod_o.sec <= 6'(bcd(data_q[`P_SEC +: 4],
                    {1'b0, data_q[`P_SEC + `P_TENS +: 3]}, 2'b00));
                tod_o.min <= 6'(bcd(data_q[`P_MIN +: 4],
                    {1'b0, data_q[`P_MIN + `P_TENS +: 3]}, 2'b00));
                tod_o.hour <= 5'(bcd(data_q[`P_HOUR +: 4],
                    {2'b00, data_q[`P_HOUR + `P_TENS +: 2]}, 2'b00));
                tod_o.day <= 9'(bcd(data_q[`P_DAY +: 4], data_q[`P_DAY + `P_TENS +: 4],
                    data_q[`P_DAY + `P_HUND +: 2]));
            end
        end
    end

    // one tick per boundary after a good frame
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            armed_q <= 1'b0;
            tick_q <= 1'b0;
        end else begin
            tick_q <= rise && armed_q;
            if (frame_q) begin
                armed_q <= 1'b1;
            end else if (rise || (fall && !valid)) begin
                armed_q <= 1'b0;
            end
        end
    end

    default clocking @(posedge clk_i); endclocking
    default disable iff (!rst_b_i);

    a_tick_single: assert property (tick_q |=> !tick_q ##1 !tick_q)
        else $error("second tick longer than one cycle");
    a_tick_after_msg: assert property (frame_q |=> !tick_q)
        else $error("tick in cycle after message");
endmodule
`default_nettype wire

// ==== irig_time_base_flywheel.sv ====
// Purpose: disciplined time base, sample clocks, flywheel and segments
// Assumes: synchronous inputs, single 50 MHz clock
// Notes: base clock is an NCO at 40 MHz mean tick rate
`timescale 1ns/10ps
`default_nettype none
`include "irig_params.svh"
module irig_time_base_flywheel #(
    parameter int unsigned US_CYC = `CLK_MHZ,
    parameter int unsigned PPS_HIGH_CYC = `PPS_HIGH_MS * `US_PER_MS * `CLK_MHZ,
    parameter int unsigned LOSS_CYC = `LOSS_MS * `US_PER_MS * `CLK_MHZ,
    parameter int unsigned BASE_HZ = `BASE_HZ
) (
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic dc_level_i,
    input wire logic am_level_i,
    input wire logic [4:0] addr_i,
    input wire logic [31:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [31:0] rdata_o,
    output logic pps_o,
    output logic sclk_o,
    output logic sync_clk_o,
    output logic acq_run_o,
    output logic seg_break_o,
    output logic seg_lost_o,
    output logic locked_o,
    output logic holdover_o,
    output logic irq_o
);
    irig_pkg::ctrl_t ctrl_q;
    irig_pkg::lock_state_t state_q;
    irig_pkg::tod_t tod_q, dec_tod;
    logic dec_tick, dec_frame, have_time_q, have_ref_q, arm_q, run_q;
    logic base_tick, sec_ev, local_tick, jump, relock, loss, brk;
    logic [32:0] nco_sum;
    logic signed [32:0] err_s;
    logic [31:0] nco_acc_q, nco_inc_q, base_cnt_q, loss_q, pps_cnt_q, rdata_q;
    logic [21:0] div_half_q, scnt_q, ycnt_q;
    logic sclk_q, yclk_q, pps_q, seg_break_q, seg_lost_q;
    logic [15:0] seg_cnt_q;
    logic [`IRQ_W-1:0] ist_q, imask_q, ev;

    function automatic logic hit(input logic [4:0] a);
        hit = addr_i == a;
    endfunction

    function automatic irig_pkg::tod_t adv(input irig_pkg::tod_t t);
        adv = t;
        if (t.sec != `SEC_LAST) begin
            adv.sec = t.sec + 6'd1;
        end else begin
            adv.sec = '0;
            if (t.min != `MIN_LAST) begin
                adv.min = t.min + 6'd1;
            end else begin
                adv.min = '0;
                if (t.hour != `HOUR_LAST) begin
                    adv.hour = t.hour + 5'd1;
                end else begin
                    adv.hour = '0;
                    adv.day = (t.day == `DAY_LAST) ? `DAY_FIRST : t.day + 9'd1;
                end
            end
        end
    endfunction

    time_code_decoder #(
        .US_CYC(US_CYC)
    ) u_dec (
        .clk_i(clk_i),
        .rst_b_i(rst_b_i),
        .ctrl_i(ctrl_q),
        .dc_level_i(dc_level_i),
        .am_level_i(am_level_i),
        .tick_o(dec_tick),
        .frame_o(dec_frame),
        .tod_o(dec_tod)
    );

    assign nco_sum = {1'b0, nco_acc_q} + {1'b0, nco_inc_q};
    assign base_tick = nco_sum[32];
    assign err_s = $signed({1'b0, 32'(BASE_HZ)}) - $signed({1'b0, base_cnt_q});
    // local second from the base count
    // count may already be past a full second on entry to holdover
    assign local_tick = state_q == irig_pkg::ST_HOLD && base_tick
                        && base_cnt_q >= 32'(BASE_HZ - 1);
    // decoder ticks count only once locked
    assign sec_ev = (state_q == irig_pkg::ST_LOCKED && dec_tick) || local_tick;
    assign loss = state_q == irig_pkg::ST_LOCKED && loss_q == 32'(LOSS_CYC);
    assign relock = state_q == irig_pkg::ST_HOLD && dec_frame;
    // frame must be one second after the last
    assign jump = state_q == irig_pkg::ST_LOCKED && dec_frame && have_time_q
                  && dec_tod != adv(tod_q);
    assign brk = run_q && (jump || relock);
    assign pps_o = pps_q;
    assign sclk_o = sclk_q;
    assign sync_clk_o = yclk_q;
    assign acq_run_o = run_q;
    assign seg_break_o = seg_break_q;
    assign seg_lost_o = seg_lost_q;
    assign locked_o = state_q == irig_pkg::ST_LOCKED;
    assign holdover_o = state_q == irig_pkg::ST_HOLD;
    assign rdata_o = rdata_q;
    assign irq_o = |(ist_q & imask_q);

    // relock on a returning valid frame
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            state_q <= irig_pkg::ST_UNLOCKED;
        end else begin
            case (state_q)
                irig_pkg::ST_UNLOCKED: begin
                    if (dec_frame) begin
                        state_q <= irig_pkg::ST_LOCKED;
                    end
                end
                irig_pkg::ST_LOCKED: begin
                    if (loss) begin
                        state_q <= irig_pkg::ST_HOLD;
                    end
                end
                irig_pkg::ST_HOLD: begin
                    if (dec_frame) begin
                        state_q <= irig_pkg::ST_LOCKED;
                    end
                end
                default: begin
                    state_q <= irig_pkg::ST_UNLOCKED;
                end
            endcase
        end
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            loss_q <= '0;
        end else if (dec_tick || dec_frame) begin
            loss_q <= '0;
        end else if (loss_q != 32'(LOSS_CYC)) begin
            loss_q <= loss_q + 32'h1;
        end
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            tod_q <= '0;
            have_time_q <= 1'b0;
        end else if (dec_frame) begin
            tod_q <= dec_tod;
            have_time_q <= 1'b1;
        end else if (local_tick) begin
            tod_q <= adv(tod_q);
        end
    end

    // phase reset each second, frequency trim on locked decoder ticks
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            nco_acc_q <= '0;
            base_cnt_q <= '0;
            nco_inc_q <= `NCO_INC_RST;
            have_ref_q <= 1'b0;
        end else begin
            if (sec_ev) begin
                nco_acc_q <= '0;
                base_cnt_q <= '0;
            end else begin
                nco_acc_q <= nco_sum[31:0];
                if (base_tick) begin
                    base_cnt_q <= base_cnt_q + 32'h1;
                end
            end
            if (state_q == irig_pkg::ST_LOCKED && dec_tick) begin
                if (have_ref_q) begin
                    nco_inc_q <= nco_inc_q + 32'(err_s <<< `NCO_GAIN_SH);
                end
                have_ref_q <= 1'b1;
            end else if (state_q != irig_pkg::ST_LOCKED) begin
                have_ref_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            pps_cnt_q <= '0;
            pps_q <= 1'b0;
        end else begin
            pps_q <= sec_ev || pps_cnt_q > 32'h1;
            if (sec_ev) begin
                pps_cnt_q <= 32'(PPS_HIGH_CYC);
            end else if (pps_cnt_q != '0) begin
                pps_cnt_q <= pps_cnt_q - 32'h1;
            end
        end
    end

    // sample divider, rise on the second
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            scnt_q <= '0;
            sclk_q <= 1'b0;
        end else if (sec_ev) begin
            scnt_q <= '0;
            sclk_q <= 1'b1;
        end else if (base_tick) begin
            if (scnt_q == div_half_q - 22'd1) begin
                scnt_q <= '0;
                sclk_q <= ~sclk_q;
            end else begin
                scnt_q <= scnt_q + 22'd1;
            end
        end
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            ycnt_q <= '0;
            yclk_q <= 1'b0;
        end else if (sec_ev) begin
            ycnt_q <= '0;
            yclk_q <= 1'b1;
        end else if (base_tick) begin
            if (ycnt_q == `SYNC_HALF - 22'd1) begin
                ycnt_q <= '0;
                yclk_q <= ~yclk_q;
            end else begin
                ycnt_q <= ycnt_q + 22'd1;
            end
        end
    end

    // start only on a second boundary
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            arm_q <= 1'b0;
            run_q <= 1'b0;
        end else if (wr_i && hit(`REG_CTRL) && wdata_i[`CTRL_STOP]) begin
            arm_q <= 1'b0;
            run_q <= 1'b0;
        end else if (wr_i && hit(`REG_CTRL) && wdata_i[`CTRL_ARM]) begin
            arm_q <= 1'b1;
        end else if (sec_ev && arm_q) begin
            arm_q <= 1'b0;
            run_q <= 1'b1;
        end
    end

    // break on relock, break on jump
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            seg_break_q <= 1'b0;
            seg_lost_q <= 1'b0;
            seg_cnt_q <= '0;
        end else begin
            seg_break_q <= brk;
            if (brk) begin
                seg_cnt_q <= seg_cnt_q + 16'd1;
                seg_lost_q <= relock;
            end
        end
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            ctrl_q <= '0;
            div_half_q <= `DIV_RST;
            imask_q <= '0;
        end else if (wr_i) begin
            if (hit(`REG_CTRL)) begin
                ctrl_q.code_a <= wdata_i[`CTRL_CODE_A];
                ctrl_q.am <= wdata_i[`CTRL_AM];
            end else if (hit(`REG_DIV)) begin
                div_half_q <= 22'(wdata_i < `DIV_MIN ? `DIV_MIN :
                                  wdata_i > `DIV_MAX ? `DIV_MAX : wdata_i);
            end else if (hit(`REG_IMASK)) begin
                imask_q <= wdata_i[`IRQ_W-1:0];
            end
        end
    end

    always_comb begin
        ev = '0;
        ev[`IRQ_SEC] = sec_ev;
        ev[`IRQ_TIME] = dec_frame;
        ev[`IRQ_LOSS] = loss;
        ev[`IRQ_RELOCK] = relock;
        ev[`IRQ_SEG] = brk;
        ev[`IRQ_START] = sec_ev && arm_q;
    end

    // events win over a write-one clear
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            ist_q <= '0;
        end else if (wr_i && hit(`REG_IST)) begin
            ist_q <= (ist_q & ~wdata_i[`IRQ_W-1:0]) | ev;
        end else begin
            ist_q <= ist_q | ev;
        end
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rdata_q <= '0;
        end else if (!rd_i) begin
            rdata_q <= '0;
        end else if (hit(`REG_CTRL)) begin
            rdata_q <= {29'h0, arm_q, ctrl_q.am, ctrl_q.code_a};
        end else if (hit(`REG_DIV)) begin
            rdata_q <= {10'h0, div_half_q};
        end else if (hit(`REG_STAT)) begin
            rdata_q <= {27'h0, have_time_q, seg_lost_q, run_q, holdover_o, locked_o};
        end else if (hit(`REG_TIME)) begin
            rdata_q <= {6'h0, tod_q};
        end else if (hit(`REG_SEG)) begin
            rdata_q <= {16'h0, seg_cnt_q};
        end else if (hit(`REG_IST)) begin
            rdata_q <= {26'h0, ist_q};
        end else if (hit(`REG_IMASK)) begin
            rdata_q <= {26'h0, imask_q};
        end else begin
            rdata_q <= '0;
        end
    end

    default clocking @(posedge clk_i); endclocking
    default disable iff (!rst_b_i);

    a_unlock_no_pps: assert property (state_q == irig_pkg::ST_UNLOCKED |-> !sec_ev)
        else $error("second pulse while unlocked");
    a_pps_high_time: assert property (sec_ev |=> pps_q && pps_cnt_q == 32'(PPS_HIGH_CYC))
        else $error("pulse width not loaded");
    a_phase_align: assert property (sec_ev |=> base_cnt_q == '0 && nco_acc_q == '0)
        else $error("base phase not reset on second");
    a_div_toggle: assert property (base_tick && !sec_ev && scnt_q == div_half_q - 22'd1
        |=> sclk_q != $past(sclk_q) && scnt_q == '0)
        else $error("sample clock missed its toggle");
    a_sclk_aligned: assert property (sec_ev |=> sclk_q ##1 sclk_q)
        else $error("sample clock rise not on second");
    a_sync_aligned: assert property (sec_ev |=> yclk_q && ycnt_q == '0)
        else $error("sync clock not aligned");
    a_hold_count: assert property (local_tick && !dec_frame |=> tod_q == adv($past(tod_q)))
        else $error("holdover time did not advance");
    a_relock_load: assert property (relock
        |=> state_q == irig_pkg::ST_LOCKED && tod_q == $past(dec_tod))
        else $error("relock did not load time");
    a_loss_status: assert property (loss |=> holdover_o && !locked_o)
        else $error("status not holdover after loss");
    a_seg_relock: assert property (relock && run_q |=> seg_break_q && seg_lost_q)
        else $error("no lost segment on relock");
    a_seg_jump: assert property (jump && run_q |=> seg_break_q && run_q)
        else $error("no segment break on jump");
    a_acq_start: assert property ($rose(run_q) |-> $past(sec_ev))
        else $error("acquisition began off a second");
endmodule
`default_nettype wire

// ==== irig_code_src.sv ====
// Purpose: time-code source model feeding the decoder inputs
// Assumes: fast format, one clock per microsecond of symbol width
// Notes: short gaps between symbols keep frames brief; line idles low
`timescale 1ns/10ps
`default_nettype none
module irig_code_src (
    input wire logic clk_i,
    output logic dc_o,
    output logic am_o
);
    // envelope comparator output follows the keyed level
    assign am_o = dc_o;
    initial dc_o = 1'b0;
    task automatic sym(input int w);
        dc_o <= 1'b1;
        repeat (w) @(posedge clk_i);
        dc_o <= 1'b0;
        repeat (4) @(posedge clk_i);
    endtask
    task automatic frame();
        sym(700);
        sym(700);
        for (int i = 1; i < 100; i++) begin
            sym((i % 10 == 9) ? 700 : (i == 30) ? 500 : 120);
        end
    endtask
endmodule
`default_nettype wire

// ==== tb_irig_time_base_flywheel.sv ====
// Purpose: self-checking bench of the disciplined time base
// Assumes: shortened counts through the top parameters
// Notes: one locked frame, a loss, relock in AM mode, then a time jump
`timescale 1ns/10ps
`default_nettype none
module tb_irig_time_base_flywheel;
    logic clk_i = 1'b0;
    logic rst_b_i = 1'b0;
    logic [4:0] addr_i = 5'h00;
    logic [31:0] wdata_i = 32'h0;
    logic wr_i = 1'b0;
    logic rd_i = 1'b0;
    logic [31:0] rdata_o, rd_v, t1;
    logic dc_l, am_l, pps_o, sclk_o, sync_clk_o, acq_run_o, seg_break_o;
    logic seg_lost_o, locked_o, holdover_o, irq_o;
    int fail_count = 0;
    int checked = 0;
    int n, h;
    int brk = 0;
    always #10 clk_i = ~clk_i;
    always @(posedge clk_i) if (seg_break_o === 1'b1) brk++;
    irig_code_src i_irig_code_src (.clk_i(clk_i), .dc_o(dc_l), .am_o(am_l));
    irig_time_base_flywheel #(.US_CYC(1), .PPS_HIGH_CYC(20), .LOSS_CYC(22000), .BASE_HZ(1000))
    i_irig_time_base_flywheel (.clk_i(clk_i), .rst_b_i(rst_b_i), .dc_level_i(dc_l),
        .am_level_i(am_l), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
        .rdata_o(rdata_o), .pps_o(pps_o), .sclk_o(sclk_o), .sync_clk_o(sync_clk_o),
        .acq_run_o(acq_run_o), .seg_break_o(seg_break_o), .seg_lost_o(seg_lost_o),
        .locked_o(locked_o), .holdover_o(holdover_o), .irq_o(irq_o));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        checked++;
        if (got !== exp) begin
            fail_count++;
            $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    task automatic wr(input logic [4:0] a, input logic [31:0] d);
        @(posedge clk_i);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge clk_i);
        wr_i <= 1'b0;
    endtask
    task automatic rd(input logic [4:0] a);
        @(posedge clk_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge clk_i);
        rd_i <= 1'b0;
        #1 rd_v = rdata_o;
    endtask
    task automatic t_reset();
        chk(locked_o, 1'b0, "locked at reset");
        chk(pps_o, 1'b0, "pulse at reset");
        rd(5'h08);
        chk(rd_v, 32'h0, "status at reset");
        rd(5'h04);
        chk(rd_v, 32'h14, "divider reset");
        wr(5'h04, 32'h1);
        rd(5'h04);
        chk(rd_v, 32'h2, "divider clamp");
        rd(5'h1c);
        chk(rd_v, 32'h0, "unmapped read");
        $display("test reset done");
    endtask
    task automatic t_lock();
        wr(5'h00, 32'h1);
        wr(5'h18, 32'h1);
        i_irig_code_src.frame();
        chk(locked_o, 1'b1, "locked after frame");
        chk(pps_o, 1'b0, "no early pulse");
        rd(5'h0c);
        chk(rd_v, 32'h00020000, "decoded time");
        wr(5'h00, 32'h5);
        fork
            i_irig_code_src.sym(850);
            begin
                n = 0;
                h = 0;
                while (pps_o !== 1'b1 && n < 10) begin
                    @(negedge clk_i);
                    n++;
                end
                chk(n > 0 && n < 6, 1'b1, "pulse on boundary");
                chk(sclk_o, 1'b1, "sample clock aligned");
                chk(sync_clk_o, 1'b1, "sync clock aligned");
                while (pps_o === 1'b1 && h < 100) begin
                    @(negedge clk_i);
                    h++;
                end
                chk(h, 20, "pulse width");
            end
        join
        chk(acq_run_o, 1'b1, "start on pulse");
        chk(irq_o, 1'b1, "second irq");
        wr(5'h14, 32'h3f);
        #1 chk(irq_o, 1'b0, "irq cleared");
        wr(5'h18, 32'h0);
        $display("test lock done");
    endtask
    task automatic t_hold();
        repeat (22500) @(posedge clk_i);
        chk(holdover_o, 1'b1, "holdover entered");
        chk(locked_o, 1'b0, "lock dropped");
        rd(5'h0c);
        t1 = rd_v;
        repeat (3000) @(posedge clk_i);
        rd(5'h0c);
        chk(rd_v !== t1, 1'b1, "flywheel time runs");
        $display("test hold done");
    endtask
    task automatic t_relock();
        wr(5'h00, 32'h3);
        i_irig_code_src.frame();
        chk(locked_o, 1'b1, "relocked");
        chk(holdover_o, 1'b0, "holdover left");
        chk(seg_lost_o, 1'b1, "break after loss");
        chk(brk != 0, 1'b1, "break pulse");
        chk(acq_run_o, 1'b1, "run continues");
        rd(5'h0c);
        chk(rd_v, 32'h00020000, "time replaced");
        $display("test relock done");
    endtask
    // repeated frame time while locked counts as a jump
    task automatic t_jump();
        i_irig_code_src.frame();
        chk(brk, 2, "break count");
        chk(seg_lost_o, 1'b0, "jump not marked lost");
        chk(acq_run_o, 1'b1, "run through jump");
        chk(locked_o, 1'b1, "lock kept on jump");
        rd(5'h10);
        chk(rd_v, 32'h2, "segment count");
        $display("test jump done");
    endtask
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    initial begin
        repeat (20) @(posedge clk_i);
        rst_b_i <= 1'b1;
        t_reset();
        t_lock();
        t_hold();
        t_relock();
        t_jump();
        print_verdict();
    end
    // watchdog about ten percent past the expected run
    initial begin
        repeat (95000) @(posedge clk_i);
        fail_count++;
        print_verdict();
    end
endmodule
`default_nettype wire
